// file: pfs_top.sv
// Pin function selector with port registers, pin drivers and port A wake-up.
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/1ns
module pfs_top
  import pfs_pkg::*;
(
  input  wire logic                  ref_clk,
  input  wire logic                  reset_n,
  input  wire pfs_pkg::pfs_bus_t     bus,
  output logic [7:0]                 rdata,
  input  wire logic                  low_power_mode,
  input  wire pfs_pkg::pfs_periph_out_t periph_out,
  output pfs_pkg::pfs_periph_in_t    periph_in,
  output pfs_pkg::pfs_route_t        route,
  output logic                       wake_up,
  input  wire pfs_pkg::pfs_pins_t    pin_in,
  output pfs_pkg::pfs_pins_t         pin_out,
  output pfs_pkg::pfs_pins_t         pin_oe
);
  import pfs_pkg::*;

  typedef struct packed {
    logic [7:0] pas_lo;
    logic [7:0] pas_hi;
    logic [7:0] pbs_lo;
    logic [7:0] pbs_hi;
    logic [7:0] pcs;
    logic [7:0] pa_dat;
    logic [7:0] pa_dir;
    logic [7:0] pa_wak;
    logic [7:0] pb_dat;
    logic [7:0] pb_dir;
    logic [1:0] pc_dat;
    logic [1:0] pc_dir;
    logic [7:0] rdata;
    logic [7:0] pa_prev;
    logic       wake;
    pfs_route_t route;
    pfs_periph_in_t pin_fn;
    pfs_pins_t  pout;
    pfs_pins_t  poe;
  } pfs_st_t;

  pfs_st_t    st_r;
  pfs_st_t    st_nxt;
  pfs_pins_t  pins_s;
  pfs_route_t rt;
  logic [7:0] pa_gpio;
  logic [7:0] pb_gpio;
  logic [1:0] pc_gpio;
  logic [7:0] pa_alt_o;
  logic [7:0] pa_alt_e;
  logic [7:0] pb_alt_o;
  logic [7:0] pb_alt_e;
  logic [1:0] pc_alt_o;
  logic [1:0] pc_alt_e;

  pfs_sync #(.W(8)) u_sync_a (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .din     (pin_in.pa),
    .dout    (pins_s.pa)
  );

  pfs_sync #(.W(8)) u_sync_b (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .din     (pin_in.pb),
    .dout    (pins_s.pb)
  );

  pfs_sync #(.W(2)) u_sync_c (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .din     (pin_in.pc),
    .dout    (pins_s.pc)
  );

  pfs_route u_route (
    .pas_lo (st_r.pas_lo),
    .pas_hi (st_r.pas_hi),
    .pbs_lo (st_r.pbs_lo),
    .pbs_hi (st_r.pbs_hi),
    .pcs    (st_r.pcs),
    .route  (rt)
  );

  // Read value of a port: pin level for inputs, latch for outputs.
  function automatic logic [7:0] port_view(input logic [7:0] dir, input logic [7:0] dat, input logic [7:0] pin);
    port_view = (dir & pin) | (~dir & dat);
  endfunction

  // Marks which pins of each port are taken by an alternate function.
  always_comb begin
    pa_gpio = 8'hFF;
    pb_gpio = 8'hFF;
    pc_gpio = 2'b11;
    pa_alt_o = '0;
    pa_alt_e = '0;
    pb_alt_o = '0;
    pb_alt_e = '0;
    pc_alt_o = '0;
    pc_alt_e = '0;
    pa_gpio[3] = ~rt.serial_chip_select;
    pa_gpio[1] = ~rt.analog_channel[4];
    pa_gpio[7] = ~(rt.serial_clock | rt.vref);
    pa_gpio[6] = ~rt.serial_data_in;
    pa_gpio[5] = ~rt.serial_data_out;
    pa_gpio[4] = ~(|rt.amplifier_one_output);
    pb_gpio[3:0] = ~rt.analog_channel[3:0];
    pb_gpio[7] = ~rt.analog_channel[7];
    pb_gpio[5] = ~rt.std_timer1_output;
    pb_gpio[4] = ~(rt.analog_channel[5] | rt.std_timer0_output);
    pc_gpio[1] = ~(rt.analog_channel[6] | rt.compact_timer_output);
    pc_gpio[0] = ~rt.io_supply_input;
    pa_alt_o[3] = periph_out.serial_chip_select;
    pa_alt_e[3] = rt.serial_chip_select & ~st_r.pa_dir[3];
    pa_alt_o[7] = periph_out.serial_clock;
    pa_alt_e[7] = rt.serial_clock & ~st_r.pa_dir[7];
    pa_alt_o[6] = periph_out.serial_data_in;
    pa_alt_e[6] = rt.serial_data_in & ~st_r.pa_dir[6];
    pa_alt_o[5] = periph_out.serial_data_out;
    pa_alt_e[5] = rt.serial_data_out;
    pb_alt_o[5] = periph_out.std_timer1_output;
    pb_alt_e[5] = rt.std_timer1_output;
    pb_alt_o[4] = periph_out.std_timer0_output;
    pb_alt_e[4] = rt.std_timer0_output;
    pc_alt_o[1] = periph_out.compact_timer_output;
    pc_alt_e[1] = rt.compact_timer_output;
  end

  always_comb begin
    logic [7:0] bw;
    logic [7:0] cur;
    logic [7:0] bmask;
    st_nxt = st_r;
    bw = bus.wdata;
    cur = '0;
    bmask = 8'h01 << bus.wdata[2:0];
    st_nxt.rdata = '0;
    if (bus.wr) begin
      unique case (bus.addr)
        PFS_OFF_PAS_LO: st_nxt.pas_lo = bw & PFS_MASK_PAS_LO;
        PFS_OFF_PAS_HI: st_nxt.pas_hi = bw & PFS_MASK_PAS_HI;
        PFS_OFF_PBS_LO: st_nxt.pbs_lo = bw & PFS_MASK_PBS_LO;
        PFS_OFF_PBS_HI: st_nxt.pbs_hi = bw & PFS_MASK_PBS_HI;
        PFS_OFF_PCS:    st_nxt.pcs    = bw & PFS_MASK_PCS;
        PFS_OFF_PA_DAT: st_nxt.pa_dat = bw;
        PFS_OFF_PA_DIR: st_nxt.pa_dir = bw;
        PFS_OFF_PA_WAK: st_nxt.pa_wak = bw;
        PFS_OFF_PB_DAT: st_nxt.pb_dat = bw;
        PFS_OFF_PB_DIR: st_nxt.pb_dir = bw;
        PFS_OFF_PC_DAT: st_nxt.pc_dat = bw[1:0];
        PFS_OFF_PC_DIR: st_nxt.pc_dir = bw[1:0];
        PFS_OFF_BITOP: begin
          // Bit operation reads the whole port A or B view or direction register, modifies one bit, writes the byte back.
          bmask = 8'h01 << bw[PFS_BITOP_IDX+:3];
          unique case (bw[PFS_BITOP_PORT+:2])
            2'd0: cur = port_view(st_r.pa_dir, st_r.pa_dat, pins_s.pa);
            2'd1: cur = st_r.pa_dir;
            2'd2: cur = port_view(st_r.pb_dir, st_r.pb_dat, pins_s.pb);
            2'd3: cur = st_r.pb_dir;
          endcase
          cur = bw[PFS_BITOP_SET] ? (cur | bmask) : (cur & ~bmask);
          unique case (bw[PFS_BITOP_PORT+:2])
            2'd0: st_nxt.pa_dat = cur;
            2'd1: st_nxt.pa_dir = cur;
            2'd2: st_nxt.pb_dat = cur;
            2'd3: st_nxt.pb_dir = cur;
          endcase
        end
        default: ;
      endcase
    end
    if (bus.rd) begin
      unique case (bus.addr)
        PFS_OFF_PAS_LO: st_nxt.rdata = st_r.pas_lo & PFS_MASK_PAS_LO;
        PFS_OFF_PAS_HI: st_nxt.rdata = st_r.pas_hi;
        PFS_OFF_PBS_LO: st_nxt.rdata = st_r.pbs_lo;
        PFS_OFF_PBS_HI: st_nxt.rdata = st_r.pbs_hi & PFS_MASK_PBS_HI;
        PFS_OFF_PCS:    st_nxt.rdata = st_r.pcs & PFS_MASK_PCS;
        PFS_OFF_PA_DAT: st_nxt.rdata = port_view(st_r.pa_dir, st_r.pa_dat, pins_s.pa);
        PFS_OFF_PA_DIR: st_nxt.rdata = st_r.pa_dir;
        PFS_OFF_PA_WAK: st_nxt.rdata = st_r.pa_wak;
        PFS_OFF_PB_DAT: st_nxt.rdata = port_view(st_r.pb_dir, st_r.pb_dat, pins_s.pb);
        PFS_OFF_PB_DIR: st_nxt.rdata = st_r.pb_dir;
        PFS_OFF_PC_DAT: st_nxt.rdata = {6'b0, st_r.pc_dir & pins_s.pc | ~st_r.pc_dir & st_r.pc_dat};
        PFS_OFF_PC_DIR: st_nxt.rdata = {6'b0, st_r.pc_dir};
        default:        st_nxt.rdata = '0;
      endcase
    end
    // Output drivers: latch value drives when direction is 0 and the pin is GPIO.
    st_nxt.pout.pa = (pa_gpio & st_r.pa_dat) | (~pa_gpio & pa_alt_o);
    st_nxt.poe.pa  = (pa_gpio & ~st_r.pa_dir) | pa_alt_e;
    st_nxt.pout.pb = (pb_gpio & st_r.pb_dat) | (~pb_gpio & pb_alt_o);
    st_nxt.poe.pb  = (pb_gpio & ~st_r.pb_dir) | pb_alt_e;
    st_nxt.pout.pc = (pc_gpio & st_r.pc_dat) | (~pc_gpio & pc_alt_o);
    st_nxt.poe.pc  = (pc_gpio & ~st_r.pc_dir) | pc_alt_e;
    st_nxt.route = rt;
    // Peripheral inputs see the synchronised pins.
    st_nxt.pin_fn.ext_irq_zero           = pa_gpio[1] & pins_s.pa[1];
    st_nxt.pin_fn.std_timer1_capture_in  = pa_gpio[1] & pins_s.pa[1];
    st_nxt.pin_fn.ext_irq_one            = pa_gpio[3] & pins_s.pa[3];
    st_nxt.pin_fn.std_timer0_clock_in    = pa_gpio[3] & pins_s.pa[3];
    st_nxt.pin_fn.std_timer0_capture_in  = pa_gpio[4] & pins_s.pa[4];
    st_nxt.pin_fn.compact_timer_clock_in = pb_gpio[7] & pins_s.pb[7];
    st_nxt.pin_fn.serial_clock           = rt.serial_clock & pins_s.pa[7];
    st_nxt.pin_fn.serial_data_in         = rt.serial_data_in & pins_s.pa[6];
    st_nxt.pin_fn.serial_chip_select     = rt.serial_chip_select & pins_s.pa[3];
    // Falling edge on an enabled GPIO input of port A while in low power.
    st_nxt.pa_prev = pins_s.pa;
    st_nxt.wake = low_power_mode &&
                  |(st_r.pa_prev & ~pins_s.pa & st_r.pa_wak & pa_gpio & st_r.pa_dir);
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r         <= '0;
      st_r.pas_lo  <= PFS_RST_SEL;
      st_r.pas_hi  <= PFS_RST_SEL;
      st_r.pbs_lo  <= PFS_RST_SEL;
      st_r.pbs_hi  <= PFS_RST_SEL;
      st_r.pcs     <= PFS_RST_SEL;
      st_r.pa_dat  <= PFS_RST_DAT;
      st_r.pa_dir  <= PFS_RST_DIR;
      st_r.pb_dat  <= PFS_RST_DAT;
      st_r.pb_dir  <= PFS_RST_DIR;
      st_r.pc_dat  <= PFS_MASK_PORTC[1:0];
      st_r.pc_dir  <= PFS_MASK_PORTC[1:0];
      st_r.pa_wak  <= PFS_RST_WAK;
      st_r.pa_prev <= PFS_RST_DAT;
      st_r.pout.pa <= PFS_RST_DAT;
      st_r.pout.pb <= PFS_RST_DAT;
      st_r.pout.pc <= PFS_MASK_PORTC[1:0];
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata     = st_r.rdata;
  assign periph_in = st_r.pin_fn;
  assign route     = st_r.route;
  assign wake_up   = st_r.wake;
  assign pin_out   = st_r.pout;
  assign pin_oe    = st_r.poe;

endmodule

// file: pfs_pkg.sv
// Package with register map, field positions, reset values and carrier types of the pin function selector.
package pfs_pkg;

  localparam int unsigned ADDR_W = 4;

  localparam logic [3:0] PFS_OFF_PAS_LO = 4'h0;
  localparam logic [3:0] PFS_OFF_PAS_HI = 4'h1;
  localparam logic [3:0] PFS_OFF_PBS_LO = 4'h2;
  localparam logic [3:0] PFS_OFF_PBS_HI = 4'h3;
  localparam logic [3:0] PFS_OFF_PCS    = 4'h4;
  localparam logic [3:0] PFS_OFF_PA_DAT = 4'h5;
  localparam logic [3:0] PFS_OFF_PA_DIR = 4'h6;
  localparam logic [3:0] PFS_OFF_PA_WAK = 4'h7;
  localparam logic [3:0] PFS_OFF_PB_DAT = 4'h8;
  localparam logic [3:0] PFS_OFF_PB_DIR = 4'h9;
  localparam logic [3:0] PFS_OFF_PC_DAT = 4'hA;
  localparam logic [3:0] PFS_OFF_PC_DIR = 4'hB;
  localparam logic [3:0] PFS_OFF_BITOP  = 4'hC;

  localparam logic [7:0] PFS_MASK_PAS_LO = 8'hCC;
  localparam logic [7:0] PFS_MASK_PAS_HI = 8'hFF;
  localparam logic [7:0] PFS_MASK_PBS_LO = 8'hFF;
  localparam logic [7:0] PFS_MASK_PBS_HI = 8'hCF;
  localparam logic [7:0] PFS_MASK_PCS    = 8'h0F;
  localparam logic [7:0] PFS_MASK_PORTC  = 8'h03;

  localparam logic [7:0] PFS_RST_SEL  = 8'h00;
  localparam logic [7:0] PFS_RST_DAT  = 8'hFF;
  localparam logic [7:0] PFS_RST_DIR  = 8'hFF;
  localparam logic [7:0] PFS_RST_WAK  = 8'h00;

  localparam logic [1:0] PFS_CODE_ALT1 = 2'b01;
  localparam logic [1:0] PFS_CODE_ALT2 = 2'b10;

  localparam int unsigned PFS_FLD_HI  = 6;
  localparam int unsigned PFS_FLD_MH  = 4;
  localparam int unsigned PFS_FLD_ML  = 2;
  localparam int unsigned PFS_FLD_LO  = 0;

  localparam int unsigned PFS_BITOP_SET  = 7;
  localparam int unsigned PFS_BITOP_PORT = 4;
  localparam int unsigned PFS_BITOP_IDX  = 0;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
    logic              wr;
    logic              rd;
  } pfs_bus_t;

  typedef struct packed {
    logic [7:0] pa;
    logic [7:0] pb;
    logic [1:0] pc;
  } pfs_pins_t;

  typedef struct packed {
    logic serial_chip_select;
    logic serial_clock;
    logic serial_data_in;
    logic serial_data_out;
    logic std_timer0_output;
    logic std_timer1_output;
    logic compact_timer_output;
  } pfs_periph_out_t;

  typedef struct packed {
    logic       serial_chip_select;
    logic       serial_clock;
    logic       serial_data_in;
    logic       serial_data_out;
    logic       vref;
    logic [1:0] amplifier_one_output;
    logic       std_timer0_output;
    logic       std_timer1_output;
    logic       compact_timer_output;
    logic [7:0] analog_channel;
    logic       io_supply_input;
  } pfs_route_t;

  typedef struct packed {
    logic ext_irq_zero;
    logic ext_irq_one;
    logic std_timer0_clock_in;
    logic std_timer1_capture_in;
    logic std_timer0_capture_in;
    logic compact_timer_clock_in;
    logic serial_clock;
    logic serial_data_in;
    logic serial_chip_select;
  } pfs_periph_in_t;

endpackage

// file: pfs_sync.sv
// Three-flop input synchroniser with a filtered output flop for one pin group.
`timescale 1ns/1ns
module pfs_sync
  import pfs_pkg::*;
#(
  parameter int unsigned W = 8
) (
  input  wire logic         ref_clk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } pfs_sync_st_t;

  pfs_sync_st_t st_r;
  pfs_sync_st_t st_nxt;

  // A change counts once the second and third stages agree.
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = din;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < W; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.q[i] = st_r.s3[i];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '{default: '1};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dout = st_r.q;

endmodule

// file: pfs_route.sv
// Decoder from selection fields to pin routing for ports A, B and C.
`timescale 1ns/1ns
module pfs_route
  import pfs_pkg::*;
(
  input  wire logic [7:0] pas_lo,
  input  wire logic [7:0] pas_hi,
  input  wire logic [7:0] pbs_lo,
  input  wire logic [7:0] pbs_hi,
  input  wire logic [7:0] pcs,
  output pfs_route_t      route
);

  function automatic logic is_code(input logic [7:0] r, input int unsigned pos, input logic [1:0] code);
    is_code = (r[pos+:2] == code);
  endfunction

  always_comb begin
    route = '0;
    route.serial_chip_select      = is_code(pas_lo, PFS_FLD_HI, PFS_CODE_ALT1);
    route.analog_channel[4]       = is_code(pas_lo, PFS_FLD_ML, PFS_CODE_ALT1);
    route.serial_clock            = is_code(pas_hi, PFS_FLD_HI, PFS_CODE_ALT1);
    route.vref                    = is_code(pas_hi, PFS_FLD_HI, PFS_CODE_ALT2);
    route.serial_data_in          = is_code(pas_hi, PFS_FLD_MH, PFS_CODE_ALT1);
    route.serial_data_out         = is_code(pas_hi, PFS_FLD_ML, PFS_CODE_ALT1);
    route.amplifier_one_output[0] = is_code(pas_hi, PFS_FLD_LO, PFS_CODE_ALT1);
    route.amplifier_one_output[1] = is_code(pas_hi, PFS_FLD_LO, PFS_CODE_ALT2);
    route.analog_channel[3]       = is_code(pbs_lo, PFS_FLD_HI, PFS_CODE_ALT1);
    route.analog_channel[2]       = is_code(pbs_lo, PFS_FLD_MH, PFS_CODE_ALT1);
    route.analog_channel[1]       = is_code(pbs_lo, PFS_FLD_ML, PFS_CODE_ALT1);
    route.analog_channel[0]       = is_code(pbs_lo, PFS_FLD_LO, PFS_CODE_ALT1);
    route.analog_channel[7]       = is_code(pbs_hi, PFS_FLD_HI, PFS_CODE_ALT1);
    route.std_timer1_output       = is_code(pbs_hi, PFS_FLD_ML, PFS_CODE_ALT1);
    route.analog_channel[5]       = is_code(pbs_hi, PFS_FLD_LO, PFS_CODE_ALT1);
    route.std_timer0_output       = is_code(pbs_hi, PFS_FLD_LO, PFS_CODE_ALT2);
    route.analog_channel[6]       = is_code(pcs, PFS_FLD_ML, PFS_CODE_ALT1);
    route.compact_timer_output    = is_code(pcs, PFS_FLD_ML, PFS_CODE_ALT2);
    route.io_supply_input         = is_code(pcs, PFS_FLD_LO, PFS_CODE_ALT1);
  end

endmodule

// file: pfs_top_assertions.sv
// Concurrent checks on the ports of the pin function selector.
`timescale 1ns/1ns
module pfs_assertions
  import pfs_pkg::*;
(
  input wire logic               ref_clk,
  input wire logic               reset_n,
  input wire pfs_pkg::pfs_bus_t  bus,
  input wire logic [7:0]         rdata,
  input wire logic               low_power_mode,
  input wire pfs_pkg::pfs_route_t route,
  input wire logic               wake_up,
  input wire pfs_pkg::pfs_pins_t pin_out,
  input wire pfs_pkg::pfs_pins_t pin_oe
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  a_pcs_unimpl_zero: assert property (
    $past(bus.rd) && $past(bus.addr) == PFS_OFF_PCS |-> rdata[7:4] == 4'h0)
    else $error("port C selector shows unimplemented bits");
  a_pas_lo_unimpl: assert property (
    $past(bus.rd) && $past(bus.addr) == PFS_OFF_PAS_LO |-> (rdata & ~PFS_MASK_PAS_LO) == 8'h00)
    else $error("port A low selector shows unimplemented bits");
  a_pbs_hi_unimpl: assert property (
    $past(bus.rd) && $past(bus.addr) == PFS_OFF_PBS_HI |-> (rdata & ~PFS_MASK_PBS_HI) == 8'h00)
    else $error("port B high selector shows unimplemented bits");
  a_route_chip_sel: assert property (
    bus.wr && bus.addr == PFS_OFF_PAS_LO ##1 !(bus.wr && bus.addr == PFS_OFF_PAS_LO)
    |=> route.serial_chip_select == ($past(bus.wdata[7:6], 2) == 2'b01))
    else $error("chip select routing does not follow its field");
  a_route_clock: assert property (
    bus.wr && bus.addr == PFS_OFF_PAS_HI ##1 !(bus.wr && bus.addr == PFS_OFF_PAS_HI)
    |=> route.serial_clock == ($past(bus.wdata[7:6], 2) == 2'b01))
    else $error("serial clock routing does not follow its field");
  a_route_vref: assert property (
    bus.wr && bus.addr == PFS_OFF_PAS_HI ##1 !(bus.wr && bus.addr == PFS_OFF_PAS_HI)
    |=> route.vref == ($past(bus.wdata[7:6], 2) == 2'b10))
    else $error("reference routing does not follow its field");
  a_route_supply: assert property (
    bus.wr && bus.addr == PFS_OFF_PCS ##1 !(bus.wr && bus.addr == PFS_OFF_PCS)
    |=> route.io_supply_input == ($past(bus.wdata[1:0], 2) == 2'b01))
    else $error("supply input routing does not follow its field");
  a_pins_reset: assert property (
    $rose(reset_n) |-> pin_out == 18'h3_FFFF && pin_oe == 18'h0_0000)
    else $error("pins are not undriven inputs after reset");
  a_wake_lpm: assert property (
    wake_up |-> $past(low_power_mode))
    else $error("wake pulse outside low power mode");
endmodule

// file: pfs_board.sv
// Board model that resolves each package pin from the device drive and the outside source.
`timescale 1ns/1ns
module pfs_board
  import pfs_pkg::*;
(
  input  wire pfs_pkg::pfs_pins_t pin_out,
  input  wire pfs_pkg::pfs_pins_t pin_oe,
  input  wire pfs_pkg::pfs_pins_t ext_level,
  output pfs_pkg::pfs_pins_t      pin_in
);
  // A driven pin shows the device level, an undriven pin the outside source.
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

// file: pfs_top_tb.sv
// Self-checking testbench of the pin function selector.
`timescale 1ns/1ns
`define CHK(got, exp) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) begin \
      $display("CHECK FAILED at %0t got %h exp %h", $time, (got), (exp)); \
      n_errors++; \
    end \
  end
module pfs_top_tb;
  import pfs_pkg::*;
  logic            ref_clk;
  logic            reset_n;
  pfs_bus_t        bus;
  logic [7:0]      rdata;
  logic            low_power_mode;
  pfs_periph_out_t periph_out;
  pfs_periph_in_t  periph_in;
  pfs_route_t      route;
  logic            wake_up;
  pfs_pins_t       pin_in;
  pfs_pins_t       pin_out;
  pfs_pins_t       pin_oe;
  pfs_pins_t       ext_level;
  int              n_errors;
  int              n_checks;
  logic [7:0]      sel [5];
  logic [7:0]      masks [5] = '{PFS_MASK_PAS_LO, PFS_MASK_PAS_HI, PFS_MASK_PBS_LO, PFS_MASK_PBS_HI, PFS_MASK_PCS};
  logic [7:0]      rst_tab [12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00,
                                    8'hFF, 8'hFF, 8'h03, 8'h03};

  pfs_top dut (.ref_clk(ref_clk), .reset_n(reset_n), .bus(bus), .rdata(rdata),
    .low_power_mode(low_power_mode), .periph_out(periph_out), .periph_in(periph_in),
    .route(route), .wake_up(wake_up), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
  pfs_board board (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level), .pin_in(pin_in));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge ref_clk);
    bus.wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge ref_clk);
    bus.rd <= 1'b0;
    @(negedge ref_clk);
    `CHK(rdata, e)
  endtask

  task automatic wait_wake(input logic e);
    logic seen;
    seen = 1'b0;
    repeat (20) begin
      @(negedge ref_clk);
      if (wake_up === 1'b1) begin
        seen = 1'b1;
      end
    end
    `CHK(seen, e)
  endtask

  function automatic pfs_route_t exp_route();
    pfs_route_t e;
    e = '0;
    e.serial_chip_select = sel[0][7:6] == 2'b01;
    e.analog_channel[4] = sel[0][3:2] == 2'b01;
    e.serial_clock = sel[1][7:6] == 2'b01;
    e.vref = sel[1][7:6] == 2'b10;
    e.serial_data_in = sel[1][5:4] == 2'b01;
    e.serial_data_out = sel[1][3:2] == 2'b01;
    e.amplifier_one_output = {sel[1][1:0] == 2'b10, sel[1][1:0] == 2'b01};
    for (int k = 0; k < 4; k++) begin
      e.analog_channel[k] = sel[2][2*k+:2] == 2'b01;
    end
    e.analog_channel[7] = sel[3][7:6] == 2'b01;
    e.std_timer1_output = sel[3][3:2] == 2'b01;
    e.analog_channel[5] = sel[3][1:0] == 2'b01;
    e.std_timer0_output = sel[3][1:0] == 2'b10;
    e.analog_channel[6] = sel[4][3:2] == 2'b01;
    e.compact_timer_output = sel[4][3:2] == 2'b10;
    e.io_supply_input = sel[4][1:0] == 2'b01;
    return e;
  endfunction

  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    reset_n = 1'b0;
    bus = '0;
    low_power_mode = 1'b0;
    periph_out = '0;
    ext_level = '1;
    n_errors = 0;
    n_checks = 0;
    tick(4);
    reset_n <= 1'b1;
    tick(6);
    for (int i = 0; i < 12; i++) begin
      rd_chk(4'(i), rst_tab[i]);
    end
    for (int i = 0; i < 5; i++) begin
      wr(4'(i), 8'hFF);
      rd_chk(4'(i), masks[i]);
      sel[i] = masks[i];
    end
    for (int r = 0; r < 5; r++) begin
      for (int c = 0; c < 4; c++) begin
        sel[r] = {4{2'(c)}} & masks[r];
        wr(4'(r), sel[r]);
        tick(2);
        @(negedge ref_clk);
        `CHK(route, exp_route())
      end
    end
    wr(PFS_OFF_PBS_HI, 8'h04);
    @(posedge ref_clk);
    periph_out.std_timer1_output <= 1'b1;
    tick(3);
    `CHK(pin_out.pb[5], 1'b1)
    `CHK(pin_oe.pb[5], 1'b1)
    periph_out.std_timer1_output <= 1'b0;
    tick(2);
    `CHK(pin_out.pb[5], 1'b0)
    wr(PFS_OFF_PBS_HI, 8'h00);
    tick(3);
    `CHK(pin_oe.pb[5], 1'b0)
    wr(PFS_OFF_PA_DIR, 8'h00);
    tick(2);
    `CHK(pin_out.pa, 8'hFF)
    `CHK(pin_oe.pa, 8'hFF)
    ext_level.pa <= 8'h00;
    wr(PFS_OFF_PA_DAT, 8'hA5);
    rd_chk(PFS_OFF_PA_DAT, 8'hA5);
    `CHK(pin_out.pa, 8'hA5)
    wr(PFS_OFF_PA_DIR, 8'hFF);
    tick(6);
    rd_chk(PFS_OFF_PA_DAT, 8'h00);
    tick(1);
    ext_level.pb <= 8'h0F;
    tick(6);
    wr(PFS_OFF_BITOP, 8'h27);
    wr(PFS_OFF_PB_DIR, 8'h00);
    rd_chk(PFS_OFF_PB_DAT, 8'h0F);
    wr(PFS_OFF_BITOP, 8'hB3);
    rd_chk(PFS_OFF_PB_DIR, 8'h08);
    tick(1);
    ext_level.pa <= 8'hFF;
    wr(PFS_OFF_PA_WAK, 8'h01);
    low_power_mode <= 1'b1;
    tick(6);
    ext_level.pa <= 8'hFE;
    wait_wake(1'b1);
    tick(1);
    ext_level.pa <= 8'hFF;
    tick(6);
    ext_level.pa <= 8'hFD;
    wait_wake(1'b0);
    `CHK(periph_in.ext_irq_zero, 1'b0)
    tick(1);
    ext_level.pa <= 8'hFF;
    low_power_mode <= 1'b0;
    tick(6);
    `CHK(periph_in.ext_irq_zero, 1'b1)
    ext_level.pa <= 8'hFE;
    wait_wake(1'b0);
    tick(1);
    ext_level.pa <= 8'hFF;
    low_power_mode <= 1'b1;
    wr(PFS_OFF_PA_DIR, 8'hFE);
    tick(6);
    wr(PFS_OFF_PA_DAT, 8'hA4);
    wait_wake(1'b0);
    wr(4'hD, 8'h55);
    rd_chk(4'hD, 8'h00);
    tick(1);
    reset_n <= 1'b0;
    tick(2);
    reset_n <= 1'b1;
    rd_chk(PFS_OFF_PAS_HI, 8'h00);
    rd_chk(PFS_OFF_PB_DIR, 8'hFF);
    conclude();
  end
endmodule

bind pfs_top pfs_assertions u_chk (.ref_clk(ref_clk), .reset_n(reset_n), .bus(bus), .rdata(rdata),
  .low_power_mode(low_power_mode), .route(route), .wake_up(wake_up), .pin_out(pin_out), .pin_oe(pin_oe));
